// ### pkg/iss_map.vh
`ifndef ISS_MAP_VH
`define ISS_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets (APB word aligned)
// ----------------------------------------------------------------------------
`define ISS_OFF_SER2_CLK_DATA   12'h000
`define ISS_OFF_SER2_SELECT     12'h004
`define ISS_OFF_CODEC_CLK_DATA  12'h008
`define ISS_OFF_CODEC_FSYNC     12'h00C
`define ISS_OFF_CAN_RX          12'h010
`define ISS_OFF_UART3           12'h014
`define ISS_OFF_UART4           12'h018

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define ISS_FLD_W               7
`define ISS_FLD_LO_LSB          0
`define ISS_FLD_LO_MSB          6
`define ISS_FLD_HI_LSB          8
`define ISS_FLD_HI_MSB          14

// ----------------------------------------------------------------------------
// Reset value and special codes
// ----------------------------------------------------------------------------
`define ISS_FLD_RESET           7'h00
`define ISS_CODE_GROUND         7'h00
`define ISS_CODE_COMPARATOR_ONE_OUTPUT           7'h01
`define ISS_CODE_MAX_NARROW     7'h7C
`define ISS_CODE_MAX_WIDE       7'h7F

`endif

// ### verilog/iss_source_mux.v
`include "iss_map.vh"

// Picks one source for one peripheral input from a 7-bit code
module iss_source_mux #(
    parameter [6:0] MAX_CODE = `ISS_CODE_MAX_NARROW
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [6:0]   sel_i,
    input  wire         cmp_i,
    input  wire [127:0] pin_i,
    output reg          out_o
);

    // Top code of every field reaches pin 124, the UART fields included
    localparam [6:0] TOP_PIN = 7'h7C;

    reg mux_d;

    // ------------------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------------------
    always @* begin
        if (sel_i == `ISS_CODE_GROUND) begin
            mux_d = 1'b0;
        end else if (sel_i == `ISS_CODE_COMPARATOR_ONE_OUTPUT) begin
            mux_d = cmp_i;
        end else if (sel_i == MAX_CODE) begin
            mux_d = pin_i[TOP_PIN];
        end else if (sel_i < MAX_CODE) begin
            mux_d = pin_i[sel_i];
        end else begin
            mux_d = 1'b0;                            // Undefined code held low
        end
    end

    // Registered output
    always @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= 1'b0;
        end else begin
            out_o <= mux_d;
        end
    end

endmodule // iss_source_mux

// ### verilog/iss_input_select_bank.v
`include "iss_map.vh"

// Contract
// - Bits 14-8 select serial port 2 clock
// - Bits 6-0 select serial port 2 data
// - Serial 2 select in bits 6-0, rest zero
// - Codec clock 14-8, codec data 6-0
// - Codec frame sync in bits 6-0
// - CAN B 14-8, CAN A 6-0
// - CAN register absent on variant without CAN
// - UART3 clear-to-send 14-8, receive 6-0
// - UART4 receive 6-0, clear-to-send 14-8
// - Code zero gives constant low input
// - Code one routes comparator one output
// - Narrow fields top code selects pin 124
// - UART fields top code selects pin 124
// - Unimplemented bits ignore writes, read zero
// - Reset clears every selection field
module iss_input_select_bank #(
    parameter HAS_CAN = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         psel_i,
    input  wire         penable_i,
    input  wire         pwrite_i,
    input  wire [11:0]  paddr_i,
    input  wire [31:0]  pwdata_i,
    output reg  [31:0]  prdata_o,
    output reg          pready_o,
    output reg          pslverr_o,
    input  wire         comparator_one_output_i,
    input  wire [127:0] remappable_pin_i,
    output wire         serial2_clock_o,
    output wire         serial2_data_o,
    output wire         serial2_select_o,
    output wire         codec_clock_input_o,
    output wire         codec_data_input_o,
    output wire         codec_frame_sync_input_o,
    output wire         can_b_receive_o,
    output wire         can_a_receive_o,
    output wire         uart3_cts_o,
    output wire         uart3_receive_o,
    output wire         uart4_cts_o,
    output wire         uart4_receive_o
);

    // ------------------------------------------------------------------------
    // Selection fields
    // ------------------------------------------------------------------------
    reg [6:0] serial2_clock_source_field_q;
    reg [6:0] serial2_data_source_field_q;
    reg [6:0] serial2_select_source_field_q;
    reg [6:0] codec_clock_source_field_q;
    reg [6:0] codec_data_source_field_q;
    reg [6:0] codec_frame_sync_source_field_q;
    reg [6:0] can_b_receive_source_field_q;
    reg [6:0] can_a_receive_source_field_q;
    reg [6:0] uart3_cts_source_field_q;
    reg [6:0] uart3_receive_source_field_q;
    reg [6:0] uart4_cts_source_field_q;
    reg [6:0] uart4_receive_source_field_q;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    reg [127:0] pin_meta_q;
    reg [127:0] pin_sync_q;
    reg         cmp_meta_q;
    reg         cmp_sync_q;

    // Two flops on every asynchronous source
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_q <= 128'h0;
            pin_sync_q <= 128'h0;
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= remappable_pin_i;
            pin_sync_q <= pin_meta_q;
            cmp_meta_q <= comparator_one_output_i;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    wire        can_present = (HAS_CAN != 0);
    wire        setup_ok    = psel_i && !penable_i;
    wire        access      = psel_i && penable_i && pready_o;
    wire        wr_en       = access && pwrite_i && !pslverr_o;
    wire        hit_s2cd    = (paddr_i == `ISS_OFF_SER2_CLK_DATA);
    wire        hit_s2s     = (paddr_i == `ISS_OFF_SER2_SELECT);
    wire        hit_ccd     = (paddr_i == `ISS_OFF_CODEC_CLK_DATA);
    wire        hit_cfs     = (paddr_i == `ISS_OFF_CODEC_FSYNC);
    wire        hit_can     = (paddr_i == `ISS_OFF_CAN_RX) && can_present;
    wire        hit_u3      = (paddr_i == `ISS_OFF_UART3);
    wire        hit_u4      = (paddr_i == `ISS_OFF_UART4);
    wire        hit_any     = hit_s2cd | hit_s2s | hit_ccd | hit_cfs |
                              hit_can | hit_u3 | hit_u4;
    wire [6:0]  wr_lo       = pwdata_i[`ISS_FLD_LO_MSB:`ISS_FLD_LO_LSB];
    wire [6:0]  wr_hi       = pwdata_i[`ISS_FLD_HI_MSB:`ISS_FLD_HI_LSB];

    // Read mux: unused bits come back zero
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_s2cd) begin
            rdata_d = {17'h0, serial2_clock_source_field_q,
                       1'b0, serial2_data_source_field_q};
        end else if (hit_s2s) begin
            rdata_d = {25'h0, serial2_select_source_field_q};
        end else if (hit_ccd) begin
            rdata_d = {17'h0, codec_clock_source_field_q,
                       1'b0, codec_data_source_field_q};
        end else if (hit_cfs) begin
            rdata_d = {25'h0, codec_frame_sync_source_field_q};
        end else if (hit_can) begin
            rdata_d = {17'h0, can_b_receive_source_field_q,
                       1'b0, can_a_receive_source_field_q};
        end else if (hit_u3) begin
            rdata_d = {17'h0, uart3_cts_source_field_q,
                       1'b0, uart3_receive_source_field_q};
        end else if (hit_u4) begin
            rdata_d = {17'h0, uart4_cts_source_field_q,
                       1'b0, uart4_receive_source_field_q};
        end
    end

    // Bus handshake: one wait-free access phase, answered from flops
    always @(posedge clk_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (setup_ok) begin
            pready_o  <= 1'b1;
            pslverr_o <= !hit_any;
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_d;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            serial2_clock_source_field_q    <= `ISS_FLD_RESET;
            serial2_data_source_field_q     <= `ISS_FLD_RESET;
            serial2_select_source_field_q   <= `ISS_FLD_RESET;
            codec_clock_source_field_q      <= `ISS_FLD_RESET;
            codec_data_source_field_q       <= `ISS_FLD_RESET;
            codec_frame_sync_source_field_q <= `ISS_FLD_RESET;
            can_b_receive_source_field_q    <= `ISS_FLD_RESET;
            can_a_receive_source_field_q    <= `ISS_FLD_RESET;
            uart3_cts_source_field_q        <= `ISS_FLD_RESET;
            uart3_receive_source_field_q    <= `ISS_FLD_RESET;
            uart4_cts_source_field_q        <= `ISS_FLD_RESET;
            uart4_receive_source_field_q    <= `ISS_FLD_RESET;
        end else if (wr_en) begin
            if (hit_s2cd) begin
                serial2_clock_source_field_q <= wr_hi;
                serial2_data_source_field_q  <= wr_lo;
            end
            if (hit_s2s) begin
                serial2_select_source_field_q <= wr_lo;
            end
            if (hit_ccd) begin
                codec_clock_source_field_q <= wr_hi;
                codec_data_source_field_q  <= wr_lo;
            end
            if (hit_cfs) begin
                codec_frame_sync_source_field_q <= wr_lo;
            end
            if (hit_can) begin
                can_b_receive_source_field_q <= wr_hi;
                can_a_receive_source_field_q <= wr_lo;
            end
            if (hit_u3) begin
                uart3_cts_source_field_q     <= wr_hi;
                uart3_receive_source_field_q <= wr_lo;
            end
            if (hit_u4) begin
                uart4_cts_source_field_q     <= wr_hi;
                uart4_receive_source_field_q <= wr_lo;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Source multiplexers
    // ------------------------------------------------------------------------
    // Serial port 2 clock input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_s2_clk (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (serial2_clock_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (serial2_clock_o)
    );

    // Serial port 2 data input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_s2_dat (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (serial2_data_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (serial2_data_o)
    );

    // Serial port 2 select input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_s2_sel (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (serial2_select_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (serial2_select_o)
    );

    // Codec interface clock input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_cd_clk (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (codec_clock_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (codec_clock_input_o)
    );

    // Codec interface data input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_cd_dat (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (codec_data_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (codec_data_input_o)
    );

    // Codec interface frame sync input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_cd_fs (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (codec_frame_sync_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (codec_frame_sync_input_o)
    );

    // Second CAN receive input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_can_b (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (can_b_receive_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (can_b_receive_o)
    );

    // First CAN receive input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_NARROW)
    ) u_can_a (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (can_a_receive_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (can_a_receive_o)
    );

    // UART3 clear-to-send input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_WIDE)
    ) u_u3_cts (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (uart3_cts_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (uart3_cts_o)
    );

    // UART3 receive input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_WIDE)
    ) u_u3_rx (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (uart3_receive_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (uart3_receive_o)
    );

    // UART4 clear-to-send input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_WIDE)
    ) u_u4_cts (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (uart4_cts_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (uart4_cts_o)
    );

    // UART4 receive input
    iss_source_mux #(
        .MAX_CODE (`ISS_CODE_MAX_WIDE)
    ) u_u4_rx (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sel_i (uart4_receive_source_field_q),
        .cmp_i (cmp_sync_q),
        .pin_i (pin_sync_q),
        .out_o (uart4_receive_o)
    );

endmodule // iss_input_select_bank

// ### tb/iss_pin_model.sv
// Far side: remappable pin levels and comparator output, changed only on clock edges
module iss_pin_model (
    input  wire logic         clk_i,
    input  wire logic [127:0] level_i,
    input  wire logic         cmp_i,
    output logic      [127:0] pin_o,
    output logic              cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins and comparator follow the levels the bench asks for
    always @(posedge clk_i) begin
        pin_o <= level_i;
        cmp_o <= cmp_i;
    end
endmodule // iss_pin_model

// ### tb/iss_input_select_bank_monitor.sv
module iss_input_select_bank_monitor #(
    parameter HAS_CAN = 1
) (
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         psel_i,
    input wire logic         penable_i,
    input wire logic         pwrite_i,
    input wire logic [11:0]  paddr_i,
    input wire logic [31:0]  pwdata_i,
    input wire logic [31:0]  prdata_o,
    input wire logic         pready_o,
    input wire logic         pslverr_o,
    input wire logic         comparator_one_output_i,
    input wire logic [127:0] remappable_pin_i,
    input wire logic         serial2_clock_o,
    input wire logic         serial2_data_o,
    input wire logic         uart3_receive_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Write accepted at this edge
    wire wr = psel_i && penable_i && pready_o && pwrite_i;
    wire rd = psel_i && penable_i && pready_o && !pwrite_i;
    AST_RST_CLEAR: assert property ($fell(rst_i)
        |-> !serial2_clock_o && !serial2_data_o && !uart3_receive_o)
        else $error("Outputs not clear after reset");
    AST_RDY_PULSE: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("Ready not a single cycle after setup");
    AST_RSVD_ZERO: assert property (rd |-> prdata_o[31:15] == 17'h0 && !prdata_o[7])
        else $error("Unimplemented bits read nonzero");
    AST_SINGLE_ZERO: assert property (rd
        && (paddr_i == 12'h004 || paddr_i == 12'h00C) |-> prdata_o[31:7] == 25'h0)
        else $error("Single field register upper bits nonzero");
    AST_UNMAPPED: assert property (pready_o |-> pslverr_o ==
        (paddr_i > 12'h018 || paddr_i[1:0] != 2'h0 || (HAS_CAN == 0 && paddr_i == 12'h010)))
        else $error("Error response wrong for address");
    AST_GND_CODE: assert property (wr && paddr_i == 12'h000 && pwdata_i[6:0] == 7'h00
        |-> ##2 !serial2_data_o)
        else $error("Ground code did not drive low");
    // Source seen at the output two edges after the write left its pin three edges earlier
    AST_CMP_CODE: assert property (wr && paddr_i == 12'h000
        && pwdata_i[6:0] == 7'h01 |-> ##2 serial2_data_o == $past(comparator_one_output_i, 3))
        else $error("Comparator code not routed");
    AST_NARROW_TOP: assert property (wr && paddr_i == 12'h000
        && pwdata_i[14:8] == 7'h7C |-> ##2 serial2_clock_o == $past(remappable_pin_i[124], 3))
        else $error("Top narrow code not routed to pin 124");
    AST_WIDE_TOP: assert property (wr && paddr_i == 12'h014
        && pwdata_i[6:0] == 7'h7F |-> ##2 uart3_receive_o == $past(remappable_pin_i[124], 3))
        else $error("Top wide code not routed to pin 124");
endmodule // iss_input_select_bank_monitor

// ### tb/iss_input_select_bank_tb_top.sv
module iss_input_select_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic         cmp_lvl = 1'b1, err_seen, pready_o, pslverr_o, comparator_one_output_i;
    logic [11:0]  paddr_i = 12'h000;
    logic [31:0]  pwdata_i = 32'h0, prdata_o, rd, want;
    logic [127:0] remappable_pin_i, pin_lvl = {32{4'h5}};
    logic [13:0]  outs;
    logic [6:0]   hi, lo;
    logic         want_hi, want_lo;
    logic [11:0]  offs [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
    int           err_total = 0, tests_run = 0;
    assign outs[3] = 1'b0;
    assign outs[7] = 1'b0;
    iss_input_select_bank i_iss_input_select_bank (.clk_i, .rst_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .comparator_one_output_i, .remappable_pin_i, .serial2_clock_o(outs[1]),
        .serial2_data_o(outs[0]), .serial2_select_o(outs[2]), .codec_clock_input_o(outs[5]),
        .codec_data_input_o(outs[4]), .codec_frame_sync_input_o(outs[6]),
        .can_b_receive_o(outs[9]), .can_a_receive_o(outs[8]), .uart3_cts_o(outs[11]),
        .uart3_receive_o(outs[10]), .uart4_cts_o(outs[13]), .uart4_receive_o(outs[12]));
    iss_pin_model i_iss_pin_model (.clk_i, .level_i(pin_lvl), .cmp_i(cmp_lvl),
        .pin_o(remappable_pin_i), .cmp_o(comparator_one_output_i));
    // Clock at 50 MHz
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) begin
            err_total++;
        end
        rd = prdata_o;
        err_seen = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // Level expected on a peripheral input for a code
    function automatic logic src(input logic [6:0] c, input bit wide);
        if (c == 7'h00) return 1'b0;
        if (c == 7'h01) return cmp_lvl;
        if (wide && c == 7'h7F) return pin_lvl[124];
        return pin_lvl[c];
    endfunction
    function automatic logic [6:0] code(input int k, input bit wide);
        case (k % 4)
            0: return 7'h00;
            1: return 7'h01;
            2: return 7'h2A;
            default: return wide ? 7'h7F : 7'h7C;
        endcase
    endfunction
    task wrap_up;
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100us;
        err_total++;
        wrap_up;
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int r = 0; r < 7; r++) begin
            apb(1'b0, offs[r], 32'h0);
            check(rd, 32'h0);
            apb(1'b1, offs[r], 32'hFFFFFFFF);
            apb(1'b0, offs[r], 32'h0);
            want = (r == 1 || r == 3) ? 32'h0000007F : 32'h00007F7F;
            check(rd, want);
        end
        apb(1'b1, 12'h01C, 32'hFFFFFFFF);
        apb(1'b0, 12'h01C, 32'h0);
        check({31'h0, err_seen}, 32'h1);
        check(rd, 32'h0);
        // Second pass runs with every source level inverted
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                for (int r = 0; r < 7; r++) begin
                    apb(1'b1, offs[r], {17'h0, code(k, r > 4), 1'b0, code(k + 1, r > 4)});
                end
                repeat (3) @(posedge clk_i);
                @(negedge clk_i);
                for (int r = 0; r < 7; r++) begin
                    hi = code(k, r > 4);
                    lo = code(k + 1, r > 4);
                    want_lo = src(lo, r > 4);
                    want_hi = (r == 1 || r == 3) ? 1'b0 : src(hi, r > 4);
                    check({31'h0, outs[2*r]}, {31'h0, want_lo});
                    check({31'h0, outs[2*r+1]}, {31'h0, want_hi});
                end
            end
            @(posedge clk_i);
            pin_lvl <= ~pin_lvl;
            cmp_lvl <= ~cmp_lvl;
        end
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check({18'h0, outs}, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        check(rd, 32'h0);
        wrap_up;
    end
endmodule // iss_input_select_bank_tb_top

bind iss_input_select_bank iss_input_select_bank_monitor #(.HAS_CAN(HAS_CAN)) i_mon (.clk_i,
    .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .comparator_one_output_i, .remappable_pin_i, .serial2_clock_o,
    .serial2_data_o, .uart3_receive_o);
